//--- hdl/hpr_pkg.sv
package hpr_pkg;

  localparam int LINK_AW = 16;
  localparam int LINK_DW = 32;

  // device register map on the link
  localparam logic [15:0] DEV_CMD_OFS     = 16'h0000;
  localparam logic [15:0] DEV_FIFO_OFS    = 16'h0004;
  localparam logic [15:0] DEV_CTRL_OFS    = 16'h0008;
  localparam logic [15:0] DEV_STAT_OFS    = 16'h000c;
  localparam int          MEM_WIN_BIT     = 15;
  localparam logic [15:0] LAYER0_START_OFS = 16'h8000;

  // device control bits
  localparam int CTL_DMA_EN_BIT  = 0;
  localparam int CTL_STOP_EN_BIT = 1;
  localparam int CTL_TMO_EN_BIT  = 2;
  localparam int CTL_AA_EN_BIT   = 3;
  localparam logic [3:0] DEV_CTRL_RST = 4'h0;

  // command word: opcode [7:0], word count minus one [11:8], first word [15:12]
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
  localparam logic [7:0] CMD_DRAW       = 8'h02;
  localparam int         CMD_CNT_LSB    = 8;
  localparam int         CMD_DST_LSB    = 12;

  localparam int         FIFO_AW      = 3;
  localparam int         FIFO_DEPTH   = 8;
  localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
  localparam int         MEM_AW       = 4;
  localparam int         MEM_WORDS    = 16;

  // ready timeout for a hung transfer
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RDY_TIMEOUT_NS  = 10000;
  localparam int RDY_TIMEOUT_CYC = RDY_TIMEOUT_NS / CLK_PERIOD_NS;

  // host controller registers on AHB-Lite
  localparam logic [7:0] H_CTRL_OFS   = 8'h00;
  localparam logic [7:0] H_LADDR_OFS  = 8'h04;
  localparam logic [7:0] H_LWDATA_OFS = 8'h08;
  localparam logic [7:0] H_LRDATA_OFS = 8'h0c;
  localparam logic [7:0] H_STAT_OFS   = 8'h10;
  localparam logic [7:0] H_DMACTL_OFS = 8'h14;
  localparam logic [7:0] H_DMADAT_OFS = 8'h18;
  localparam int H_GO_BIT     = 0;
  localparam int H_SEQ_BIT    = 1;
  localparam int H_BUS16_BIT  = 2;
  localparam int H_LWR_BIT    = 16;
  localparam int DMA_RUN_BIT  = 30;
  localparam int DMA_EN_BIT   = 31;

  typedef enum logic [2:0] {
    RG_CMD  = 3'b000,
    RG_FIFO = 3'b001,
    RG_CTRL = 3'b010,
    RG_STAT = 3'b011,
    RG_MEM  = 3'b100,
    RG_NONE = 3'b101
  } hpr_region_t;

  function automatic hpr_region_t hpr_decode(input logic [15:0] a);
    if (a[MEM_WIN_BIT])       return RG_MEM;
    else if (a == DEV_CMD_OFS)  return RG_CMD;
    else if (a == DEV_FIFO_OFS) return RG_FIFO;
    else if (a == DEV_CTRL_OFS) return RG_CTRL;
    else if (a == DEV_STAT_OFS) return RG_STAT;
    else                        return RG_NONE;
  endfunction

endpackage

//--- hdl/hpr_link_if.sv
`timescale 1ns/1ps
interface hpr_link_if;
  logic        strobe;
  logic        write;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        bus16;
  logic        host_transfer_ready;
  logic        dma_req;
  logic        dma_stop_pulse;

  modport dev (input strobe, input write, input addr, input wdata, input bus16,
               output rdata, output host_transfer_ready, output dma_req, output dma_stop_pulse);
  modport host (output strobe, output write, output addr, output wdata, output bus16,
                input rdata, input host_transfer_ready, input dma_req, input dma_stop_pulse);
endinterface

//--- hdl/hpr_sync.sv
`timescale 1ns/1ps
module hpr_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- hdl/hpr_device.sv
`timescale 1ns/1ps
module hpr_device
  import hpr_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  hpr_link_if.dev   lnk,
  output logic      cmd_busy,
  output logic      ready_hung
);
  logic                bus16_s;
  logic [LINK_DW-1:0]  fifo_mem [FIFO_DEPTH];
  logic [LINK_DW-1:0]  pix_mem  [MEM_WORDS];
  logic [FIFO_AW:0]    wr_ptr_q;
  logic [FIFO_AW:0]    rd_ptr_q;
  logic [FIFO_AW:0]    fifo_cnt;
  logic                fifo_full;
  logic                fifo_empty;
  logic [LINK_DW-1:0]  fifo_head;
  logic [3:0]          ctrl_q;
  logic                busy_q;
  logic                cut_q;
  logic                stale_q;
  logic [3:0]          left_q;
  logic [MEM_AW-1:0]   dst_q;
  logic                pend_q;
  logic [MEM_AW-1:0]   pend_addr_q;
  logic [LINK_DW-1:0]  pend_data_q;
  logic                ready_q;
  logic                hung_q;
  logic [7:0]          tmo_q;
  logic [LINK_DW-1:0]  rdata_q;
  logic                stop_q;
  logic                dma_q;
  hpr_region_t         rg;
  logic                acc;
  logic                rd_acc;
  logic                hang_set;
  logic                push;
  logic                cmd_wr;
  logic [7:0]          opcode;
  logic                soft_rst;
  logic                draw_go;
  logic                pop;
  logic                draw_end;
  logic                tmo_hit;

  hpr_sync #(.W(1)) u_bus16_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (lnk.bus16),
    .q       (bus16_s)
  );

  assign fifo_cnt   = wr_ptr_q - rd_ptr_q;
  assign fifo_full  = (fifo_cnt == FIFO_FULL_CNT);
  assign fifo_empty = (wr_ptr_q == rd_ptr_q);
  assign fifo_head  = fifo_mem[rd_ptr_q[FIFO_AW-1:0]];
  assign rg         = hpr_decode(lnk.addr);
  assign opcode     = lnk.wdata[7:0];

  // a fifo write waits while the fifo is full, a draw command while a draw is still running
  always_comb begin
    acc = lnk.strobe & ~ready_q & ~hung_q;
    if (lnk.write && rg == RG_FIFO && fifo_full)
      acc = 1'b0;
    if (lnk.write && rg == RG_CMD && opcode == CMD_DRAW && busy_q)
      acc = 1'b0;
  end

  assign rd_acc   = acc & ~lnk.write;
  assign hang_set = rd_acc & (rg == RG_FIFO) & bus16_s;
  assign push     = acc & lnk.write & (rg == RG_FIFO);
  assign cmd_wr   = acc & lnk.write & (rg == RG_CMD);
  assign soft_rst = cmd_wr & (opcode == CMD_SOFT_RESET);
  assign draw_go  = cmd_wr & (opcode == CMD_DRAW);
  assign pop      = busy_q & ~fifo_empty & ~soft_rst;
  assign draw_end = pop & ((left_q == 4'h0) | cut_q);
  assign tmo_hit  = hung_q & ctrl_q[CTL_TMO_EN_BIT] & (tmo_q == 8'(RDY_TIMEOUT_CYC - 1));

  // input fifo: host pushes, pixel processor pops, soft reset flushes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (soft_rst)
        rd_ptr_q <= wr_ptr_q;
      else if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge hclk) begin
    if (push)
      fifo_mem[wr_ptr_q[FIFO_AW-1:0]] <= lnk.wdata;
  end

  // pixel memory: engine writes one cycle after pop, host writes directly
  always_ff @(posedge hclk) begin
    if (pend_q) begin
      if (soft_rst && ctrl_q[CTL_AA_EN_BIT])
        pix_mem[0] <= pend_data_q;
      else
        pix_mem[pend_addr_q] <= pend_data_q;
    end
    if (acc && lnk.write && rg == RG_MEM)
      pix_mem[lnk.addr[MEM_AW+1:2]] <= lnk.wdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q      <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= '0;
    end else begin
      pend_q      <= pop;
      pend_addr_q <= dst_q;
      pend_data_q <= fifo_head;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl_q <= DEV_CTRL_RST;
    else if (acc && lnk.write && rg == RG_CTRL)
      ctrl_q <= lnk.wdata[3:0];
  end

  // command engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q  <= 1'b0;
      cut_q   <= 1'b0;
      stale_q <= 1'b0;
      left_q  <= '0;
      dst_q   <= '0;
    end else begin
      if (soft_rst) begin
        busy_q  <= 1'b0;
        stale_q <= 1'b1;
      end else if (draw_go) begin
        busy_q  <= 1'b1;
        cut_q   <= stale_q;
        stale_q <= 1'b0;
        left_q  <= lnk.wdata[CMD_CNT_LSB +: 4];
        dst_q   <= lnk.wdata[CMD_DST_LSB +: MEM_AW];
      end else if (pop) begin
        dst_q  <= dst_q + 1'b1;
        left_q <= left_q - 1'b1;
        if (draw_end)
          busy_q <= 1'b0;
      end
      // a no-op clears the stale flag, so the next draw after a soft reset is not cut short
      if (cmd_wr && opcode == CMD_NOP)
        stale_q <= 1'b0;
    end
  end

  // stop pulse only on a normal end; soft reset and enable drop give none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_q <= 1'b0;
      dma_q  <= 1'b0;
    end else begin
      stop_q <= draw_end & ctrl_q[CTL_DMA_EN_BIT] & ctrl_q[CTL_STOP_EN_BIT];
      // drop the request with the last pop, so no extra word follows the draw
      dma_q  <= ctrl_q[CTL_DMA_EN_BIT] & busy_q & ~draw_end & ~soft_rst & ~fifo_full;
    end
  end

  // transfer ready and its timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
      hung_q  <= 1'b0;
      tmo_q   <= '0;
    end else begin
      ready_q <= (acc & ~hang_set) | tmo_hit;
      if (hang_set)
        hung_q <= 1'b1;
      else if (tmo_hit)
        hung_q <= 1'b0;
      if (hung_q && !tmo_hit)
        tmo_q <= tmo_q + 1'b1;
      else
        tmo_q <= '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (tmo_hit) begin
      rdata_q <= '0;
    end else if (rd_acc) begin
      unique case (rg)
        RG_FIFO: rdata_q <= fifo_head;
        RG_CTRL: rdata_q <= {28'h0000000, ctrl_q};
        RG_STAT: rdata_q <= {24'h000000, hung_q, stale_q, cut_q, busy_q, fifo_cnt};
        RG_MEM:  rdata_q <= pix_mem[lnk.addr[MEM_AW+1:2]];
        default: rdata_q <= '0;
      endcase
    end
  end

  assign lnk.rdata               = rdata_q;
  assign lnk.host_transfer_ready = ready_q;
  assign lnk.dma_req             = dma_q;
  assign lnk.dma_stop_pulse      = stop_q;
  assign cmd_busy                = busy_q;
  assign ready_hung              = hung_q;

endmodule

//--- hdl/hpr_host.sv
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module hpr_host
  import hpr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  hpr_link_if.host         lnk
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_XFER    = 3'b001,
    ST_DMA30   = 3'b010,
    ST_DMA31   = 3'b011,
    ST_SAVE    = 3'b100,
    ST_RST     = 3'b101,
    ST_NOP     = 3'b110,
    ST_RESTORE = 3'b111
  } hpr_hstate_t;

  hpr_hstate_t st_q;
  hpr_hstate_t ret_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        bus16_q;
  logic [16:0] laddr_q;
  logic [31:0] lwdata_q;
  logic [31:0] lrdata_q;
  logic        refused_q;
  logic [31:0] dmactl_q;
  logic [31:0] dmadat_q;
  logic        strobe_q;
  logic        lwr_q;
  logic [15:0] lad_q;
  logic [31:0] lwd_q;
  logic        ctrl_wr;
  logic        go;
  logic        seq_go;
  logic        bad_read;
  logic        dma_go;

  assign ctrl_wr  = wr_pend_q & (wr_addr_q == H_CTRL_OFS);
  assign go       = ctrl_wr & hwdata[H_GO_BIT] & (st_q == ST_IDLE);
  assign seq_go   = ctrl_wr & hwdata[H_SEQ_BIT] & (st_q == ST_IDLE) & ~go;
  // a width bit written together with go counts as well, old or new
  assign bad_read = ~laddr_q[H_LWR_BIT] & (laddr_q[15:0] == DEV_FIFO_OFS) &
                    (bus16_q | (ctrl_wr & hwdata[H_BUS16_BIT]));
  assign dma_go   = (st_q == ST_IDLE) & ~ctrl_wr & dmactl_q[DMA_EN_BIT] & dmactl_q[DMA_RUN_BIT] & lnk.dma_req;

  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q  <= '0;
    end else begin
      wr_pend_q <= hsel & htrans[1] & hready & hwrite;
      wr_addr_q <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        unique case (haddr[7:0])
          H_CTRL_OFS:   hrdata_q <= {29'h00000000, bus16_q, 2'b00};
          H_LADDR_OFS:  hrdata_q <= {15'h0000, laddr_q};
          H_LWDATA_OFS: hrdata_q <= lwdata_q;
          H_LRDATA_OFS: hrdata_q <= lrdata_q;
          H_STAT_OFS:   hrdata_q <= {30'h00000000, refused_q, st_q != ST_IDLE};
          H_DMACTL_OFS: hrdata_q <= dmactl_q;
          H_DMADAT_OFS: hrdata_q <= dmadat_q;
          default:      hrdata_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus16_q   <= 1'b0;
      laddr_q   <= '0;
      lwdata_q  <= '0;
      refused_q <= 1'b0;
    end else begin
      if (ctrl_wr)
        bus16_q <= hwdata[H_BUS16_BIT];
      if (wr_pend_q && wr_addr_q == H_LADDR_OFS)
        laddr_q <= hwdata[16:0];
      if (wr_pend_q && wr_addr_q == H_LWDATA_OFS)
        lwdata_q <= hwdata;
      if (go && bad_read)
        refused_q <= 1'b1;
      else if (wr_pend_q && wr_addr_q == H_STAT_OFS && hwdata[1])
        refused_q <= 1'b0;
    end
  end

  // dma control: bit 31 may only fall once bit 30 is already clear, or together with it on a stop pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dmactl_q <= '0;
      dmadat_q <= '0;
    end else begin
      if (lnk.dma_stop_pulse) begin
        dmactl_q[DMA_RUN_BIT] <= 1'b0;
        dmactl_q[DMA_EN_BIT]  <= 1'b0;
      end
      if (st_q == ST_DMA30)
        dmactl_q[DMA_RUN_BIT] <= 1'b0;
      else if (st_q == ST_DMA31)
        dmactl_q[DMA_EN_BIT] <= 1'b0;
      else if (wr_pend_q && wr_addr_q == H_DMACTL_OFS) begin
        dmactl_q                 <= hwdata;
        dmactl_q[DMA_EN_BIT]     <= hwdata[DMA_EN_BIT] | dmactl_q[DMA_RUN_BIT];
      end
      if (dma_go)
        dmadat_q <= dmadat_q + 32'h00000001;
      else if (wr_pend_q && wr_addr_q == H_DMADAT_OFS)
        dmadat_q <= hwdata;
    end
  end

  // link sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= ST_IDLE;
      ret_q    <= ST_IDLE;
      strobe_q <= 1'b0;
      lwr_q    <= 1'b0;
      lad_q    <= '0;
      lwd_q    <= '0;
      lrdata_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (go && !bad_read) begin
            strobe_q <= 1'b1;
            lwr_q    <= laddr_q[H_LWR_BIT];
            lad_q    <= laddr_q[15:0];
            lwd_q    <= lwdata_q;
            ret_q    <= ST_IDLE;
            st_q     <= ST_XFER;
          end else if (seq_go) begin
            st_q <= ST_DMA30;
          end else if (dma_go) begin
            strobe_q <= 1'b1;
            lwr_q    <= 1'b1;
            lad_q    <= DEV_FIFO_OFS;
            lwd_q    <= dmadat_q;
            ret_q    <= ST_IDLE;
            st_q     <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (lnk.host_transfer_ready) begin
            strobe_q <= 1'b0;
            if (!lwr_q)
              lrdata_q <= lnk.rdata;
            st_q <= ret_q;
          end
        end
        ST_DMA30: st_q <= ST_DMA31;
        ST_DMA31: st_q <= ST_SAVE;
        ST_SAVE: begin
          strobe_q <= 1'b1;
          lwr_q    <= 1'b0;
          lad_q    <= LAYER0_START_OFS;
          ret_q    <= ST_RST;
          st_q     <= ST_XFER;
        end
        ST_RST: begin
          strobe_q <= 1'b1;
          lwr_q    <= 1'b1;
          lad_q    <= DEV_CMD_OFS;
          lwd_q    <= {24'h000000, CMD_SOFT_RESET};
          ret_q    <= ST_NOP;
          st_q     <= ST_XFER;
        end
        ST_NOP: begin
          strobe_q <= 1'b1;
          lwr_q    <= 1'b1;
          lad_q    <= DEV_CMD_OFS;
          lwd_q    <= {24'h000000, CMD_NOP};
          ret_q    <= ST_RESTORE;
          st_q     <= ST_XFER;
        end
        ST_RESTORE: begin
          strobe_q <= 1'b1;
          lwr_q    <= 1'b1;
          lad_q    <= LAYER0_START_OFS;
          lwd_q    <= lrdata_q;
          ret_q    <= ST_IDLE;
          st_q     <= ST_XFER;
        end
      endcase
    end
  end

  assign hrdata     = hrdata_q;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign lnk.strobe = strobe_q;
  assign lnk.write  = lwr_q;
  assign lnk.addr   = lad_q;
  assign lnk.wdata  = lwd_q;
  assign lnk.bus16  = bus16_q;

endmodule

//--- dv/hpr_link_asserts.sv
`timescale 1ns/1ps
module hpr_link_asserts
  import hpr_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        strobe,
  input wire logic        write,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        bus16,
  input wire logic        host_transfer_ready,
  input wire logic        dma_req,
  input wire logic        dma_stop_pulse
);
  logic stop_en_q;
  logic dma_en_q;
  wire  ctl_wr = strobe && write && host_transfer_ready && addr == DEV_CTRL_OFS;

  // shadow of the device control word, updated when a control write completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_en_q <= 1'b0;
      dma_en_q  <= 1'b0;
    end else if (ctl_wr) begin
      stop_en_q <= wdata[CTL_STOP_EN_BIT];
      dma_en_q  <= wdata[CTL_DMA_EN_BIT];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RDY_ONE_CYCLE: assert property (host_transfer_ready |=> !host_transfer_ready)
    else $error("ready high for more than one cycle");
  AST_RDY_IN_ACCESS: assert property (host_transfer_ready |-> strobe)
    else $error("ready without a request");
  AST_STROBE_HELD: assert property (strobe && !host_transfer_ready |=>
    strobe && $stable(addr) && $stable(write) && $stable(wdata))
    else $error("request changed before ready");
  AST_STROBE_DROPS: assert property (strobe && host_transfer_ready |=> !strobe)
    else $error("request not dropped after ready");
  AST_NO_FIFO_READ16: assert property (strobe && !write && addr == DEV_FIFO_OFS |-> !bus16)
    else $error("fifo read issued in 16-bit mode");
  AST_NO_HANG: assert property ($rose(strobe) |-> ##[1:1000] host_transfer_ready)
    else $error("link access hung");
  AST_STOP_NEEDS_EN: assert property (dma_stop_pulse |-> stop_en_q)
    else $error("stop pulse while stop pulse disabled");
  AST_STOP_ONE_CYCLE: assert property (dma_stop_pulse |=> !dma_stop_pulse)
    else $error("stop pulse longer than one cycle");
  AST_REQ_NEEDS_EN: assert property (dma_req |-> dma_en_q || (ctl_wr && wdata[CTL_DMA_EN_BIT]))
    else $error("dma request while dma disabled");
endmodule

//--- dv/host_port_reset_dma_behaviour_tb_top.sv
`timescale 1ns/1ps
module host_port_reset_dma_behaviour_tb_top;
  import hpr_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        cmd_busy;
  logic        ready_hung;
  logic [31:0] rv;
  logic        b16;
  int          failures;
  int          samples_checked;
  int          stops;

  hpr_link_if lnk_if();
  hpr_host u_hpr_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk_if));
  hpr_device u_hpr_device (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_if), .cmd_busy(cmd_busy),
    .ready_hung(ready_hung));
  hpr_link_asserts u_hpr_link_asserts (.hclk(hclk), .hresetn(hresetn), .strobe(lnk_if.strobe),
    .write(lnk_if.write), .addr(lnk_if.addr), .wdata(lnk_if.wdata), .bus16(lnk_if.bus16),
    .host_transfer_ready(lnk_if.host_transfer_ready), .dma_req(lnk_if.dma_req),
    .dma_stop_pulse(lnk_if.dma_stop_pulse));

  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    if (lnk_if.dma_stop_pulse === 1'b1) stops++;
  end

  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    ahb(1'b0, H_STAT_OFS, 32'h0);
    while (rv[0] !== 1'b0 && n < 500) begin
      ahb(1'b0, H_STAT_OFS, 32'h0);
      n++;
    end
    if (rv[0] !== 1'b0) begin
      failures++;
      $display("[FAIL] %0t link sequencer stayed busy", $time);
    end
  endtask

  task automatic lnk(input logic w, input logic [15:0] a, input logic [31:0] d);
    ahb(1'b1, H_LADDR_OFS, {15'h0, w, a});
    ahb(1'b1, H_LWDATA_OFS, d);
    ahb(1'b1, H_CTRL_OFS, {29'h0, b16, 2'b01});
    wait_idle();
    if (!w) ahb(1'b0, H_LRDATA_OFS, 32'h0);
  endtask

  function automatic logic [31:0] draw(input logic [3:0] dst, input logic [3:0] cnt_m1);
    return {16'h0, dst, cnt_m1, CMD_DRAW};
  endfunction

  task automatic t_mem;
    lnk(1'b1, 16'h800c, 32'h1234_5678);
    lnk(1'b0, 16'h800c, 32'h0);
    chk(rv, 32'h1234_5678);
  endtask

  task automatic t_fifo_draw;
    lnk(1'b1, DEV_FIFO_OFS, 32'haaaa_0001);
    lnk(1'b1, DEV_FIFO_OFS, 32'hbbbb_0002);
    lnk(1'b0, DEV_FIFO_OFS, 32'h0);
    chk(rv, 32'haaaa_0001);
    lnk(1'b0, DEV_STAT_OFS, 32'h0);
    chk({28'h0, rv[3:0]}, 32'h2);
    lnk(1'b1, DEV_CMD_OFS, draw(4'h5, 4'h1));
    lnk(1'b0, 16'h8014, 32'h0);
    chk(rv, 32'haaaa_0001);
    lnk(1'b0, 16'h8018, 32'h0);
    chk(rv, 32'hbbbb_0002);
  endtask

  task automatic t_bus16;
    b16 = 1'b1;
    lnk(1'b0, DEV_FIFO_OFS, 32'h0);
    ahb(1'b0, H_STAT_OFS, 32'h0);
    chk({30'h0, rv[1:0]}, 32'h2);
    chk({31'h0, ready_hung}, 32'h0);
    lnk(1'b0, DEV_STAT_OFS, 32'h0);
    chk({24'h0, rv[7:0]}, 32'h0);
    ahb(1'b1, H_STAT_OFS, 32'h2);
    ahb(1'b0, H_STAT_OFS, 32'h0);
    chk({31'h0, rv[1]}, 32'h0);
    b16 = 1'b0;
  endtask

  task automatic t_soft_reset_command;
    lnk(1'b1, DEV_FIFO_OFS, 32'hcccc_0003);
    lnk(1'b1, DEV_CMD_OFS, {24'h0, CMD_SOFT_RESET});
    lnk(1'b0, DEV_STAT_OFS, 32'h0);
    chk({25'h0, rv[6], 2'b00, rv[3:0]}, 32'h40);
    lnk(1'b1, 16'h8024, 32'heeee_0005);
    lnk(1'b1, DEV_FIFO_OFS, 32'hcccc_0003);
    lnk(1'b1, DEV_FIFO_OFS, 32'hdddd_0004);
    lnk(1'b1, DEV_CMD_OFS, draw(4'h8, 4'h1));
    lnk(1'b0, 16'h8024, 32'h0);
    chk(rv, 32'heeee_0005);
    lnk(1'b1, DEV_CMD_OFS, {24'h0, CMD_SOFT_RESET});
    lnk(1'b1, DEV_CMD_OFS, {24'h0, CMD_NOP});
    lnk(1'b1, DEV_FIFO_OFS, 32'hcccc_0003);
    lnk(1'b1, DEV_FIFO_OFS, 32'hdddd_0004);
    lnk(1'b1, DEV_CMD_OFS, draw(4'ha, 4'h1));
    lnk(1'b0, 16'h802c, 32'h0);
    chk(rv, 32'hdddd_0004);
  endtask

  task automatic t_reset_seq;
    lnk(1'b1, LAYER0_START_OFS, 32'h5a5a_a5a5);
    lnk(1'b1, DEV_CTRL_OFS, 32'h8);
    ahb(1'b1, H_DMACTL_OFS, 32'hc000_0000);
    ahb(1'b1, H_CTRL_OFS, 32'h2);
    wait_idle();
    ahb(1'b0, H_DMACTL_OFS, 32'h0);
    chk(rv, 32'h0);
    ahb(1'b0, H_LRDATA_OFS, 32'h0);
    chk(rv, 32'h5a5a_a5a5);
    lnk(1'b0, LAYER0_START_OFS, 32'h0);
    chk(rv, 32'h5a5a_a5a5);
    lnk(1'b0, DEV_STAT_OFS, 32'h0);
    chk({31'h0, rv[6]}, 32'h0);
  endtask

  task automatic t_dma_stop;
    int n;
    lnk(1'b1, DEV_CTRL_OFS, 32'h3);
    lnk(1'b1, DEV_CMD_OFS, draw(4'hc, 4'h3));
    ahb(1'b1, H_DMADAT_OFS, 32'h100);
    ahb(1'b1, H_DMACTL_OFS, 32'hc000_0000);
    n = 0;
    ahb(1'b0, H_DMACTL_OFS, 32'h0);
    while (rv !== 32'h0 && n < 500) begin
      ahb(1'b0, H_DMACTL_OFS, 32'h0);
      n++;
    end
    chk(rv, 32'h0);
    chk(stops, 1);
    for (int i = 0; i < 4; i++) begin
      lnk(1'b0, 16'h8030 + 16'(4 * i), 32'h0);
      chk(rv, 32'h100 + i);
    end
  endtask

  task automatic t_no_stop;
    lnk(1'b1, DEV_CTRL_OFS, 32'h1);
    lnk(1'b1, DEV_CMD_OFS, draw(4'he, 4'h0));
    ahb(1'b1, H_DMACTL_OFS, 32'hc000_0000);
    repeat (100) @(posedge hclk);
    chk(stops, 1);
    ahb(1'b1, H_DMACTL_OFS, 32'h4000_0000);
    ahb(1'b0, H_DMACTL_OFS, 32'h0);
    chk(rv, 32'hc000_0000);
    ahb(1'b1, H_DMACTL_OFS, 32'h8000_0000);
    ahb(1'b0, H_DMACTL_OFS, 32'h0);
    chk(rv, 32'h8000_0000);
    ahb(1'b1, H_DMACTL_OFS, 32'h0);
    ahb(1'b0, H_DMACTL_OFS, 32'h0);
    chk(rv, 32'h0);
    lnk(1'b1, DEV_CTRL_OFS, 32'h3);
    lnk(1'b1, DEV_CMD_OFS, draw(4'h0, 4'hf));
    ahb(1'b1, H_DMACTL_OFS, 32'h8000_0000);
    repeat (20) @(posedge hclk);
    chk({31'h0, cmd_busy}, 32'h1);
    ahb(1'b1, H_CTRL_OFS, 32'h2);
    wait_idle();
    chk(stops, 1);
    chk({31'h0, cmd_busy}, 32'h0);
    ahb(1'b0, H_DMACTL_OFS, 32'h0);
    chk(rv, 32'h0);
  endtask

  initial begin
    #3000000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    b16     = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_mem();
    t_fifo_draw();
    t_bus16();
    t_soft_reset_command();
    t_reset_seq();
    t_dma_stop();
    t_no_stop();
    report_and_stop();
  end
endmodule
